// *** logic/dbt_pkg.sv ***
// Constants, types and state codes for the serial debug test port.
// Assumes one system clock domain; test pins arrive asynchronously.
//
// Function
// RQ1 - Sixteen-state port controller steps on each rising test clock by test mode select.
// RQ2 - After power-on reset the controller sits in Test-Logic-Reset.
// RQ3 - Every shift register moves least significant bit first, in and out.
// RQ4 - From Run-Test/Idle the controller drives mode select 1,1,0,0 to reach Shift-IR.
// RQ5 - Instruction is four bits; top bit enters on the edge leaving Shift-IR.
// RQ6 - Instruction shifting sends out the fixed captured value 0001.
// RQ7 - Mode select 1,1,0 returns to idle; instruction is latched in Update-IR.
// RQ8 - Mode select 1,0,0 reaches Shift-DR; last bit enters on the exit edge.
// RQ9 - Shift-DR sends out what the selected data register captured in Capture-DR.
// RQ10 - Latched data register outputs change only in Update-DR.
// RQ11 - Exit, Pause and Exit2 states only steer; no register action there.
// RQ12 - Data shifting may follow instruction update without passing Run-Test/Idle.
// RQ13 - Five test clocks with mode select high reach Test-Logic-Reset from anywhere.
// RQ14 - Enable fuse unprogrammed: pins are ordinary I/O, controller held in reset.
// RQ15 - Fuse programmed, disable bit clear: pull test inputs high, enable the port.
// RQ16 - Test data out floats except in the shift states.
// RQ17 - Debugger watches the reset pin and may pull it low through open-collector; the port has no reset pin output.
// RQ18 - Debug access feeds processor instructions; results return via a communication byte.
// RQ19 - Break on flow change, single step, two program and two combined break points.
// RQ20 - Break points form four program, 3+1, 2+2, or two plus one masked range.
// RQ21 - Debug works only with both fuses programmed and no lock bit set.
// RQ22 - Opcodes 8 to 11 are the private debug access instructions.
// RQ23 - Test data out changes on the falling test clock edge.
package dbt_pkg;

	localparam int IR_W = 4;
	localparam int ADR_W = 16;
	localparam int BP_N = 4;
	localparam int DR_MAX = 69;

	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] IR_RESET_VAL = 4'hf;
	localparam logic [IR_W-1:0] OP_DEBUG_INSTR_A = 4'h8;
	localparam logic [IR_W-1:0] OP_DEBUG_INSTR_B = 4'h9;
	localparam logic [IR_W-1:0] OP_DEBUG_INSTR_C = 4'ha;
	localparam logic [IR_W-1:0] OP_DEBUG_INSTR_D = 4'hb;

	// Chain lengths per selected path
	localparam logic [6:0] LEN_BYPASS = 7'h01;
	localparam logic [6:0] LEN_CPU = 7'h10;
	localparam logic [6:0] LEN_BP = 7'h45;
	localparam logic [6:0] LEN_COMM = 7'h09;
	localparam logic [6:0] LEN_STAT = 7'h08;

	// Break point arrangements
	localparam logic [2:0] BPM_4PROG = 3'h0;
	localparam logic [2:0] BPM_3PROG_1DATA = 3'h1;
	localparam logic [2:0] BPM_2PROG_2DATA = 3'h2;
	localparam logic [2:0] BPM_2PROG_PRANGE = 3'h3;
	localparam logic [2:0] BPM_2PROG_DRANGE = 3'h4;

	// Break cause bit positions
	localparam int CAUSE_PROG = 0;
	localparam int CAUSE_DATA = 1;
	localparam int CAUSE_FLOW = 2;
	localparam int CAUSE_STEP = 3;

	localparam logic [7:0] COMM_RESET = 8'h00;
	localparam logic [3:0] CAUSE_RESET = 4'h0;

	typedef enum logic [3:0] {
		ST_RESET = 4'h0,
		ST_IDLE = 4'h1,
		ST_SEL_DR = 4'h3,
		ST_CAP_DR = 4'h2,
		ST_SHIFT_DR = 4'h6,
		ST_EXIT1_DR = 4'h7,
		ST_PAUSE_DR = 4'h5,
		ST_EXIT2_DR = 4'h4,
		ST_UPD_DR = 4'hc,
		ST_SEL_IR = 4'hd,
		ST_CAP_IR = 4'hf,
		ST_SHIFT_IR = 4'he,
		ST_EXIT1_IR = 4'ha,
		ST_PAUSE_IR = 4'hb,
		ST_EXIT2_IR = 4'h9,
		ST_UPD_IR = 4'h8
	} dbt_state_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} dbt_pins_s;

	typedef struct packed {
		logic [2:0] mode;
		logic flow_en;
		logic step_en;
		logic [BP_N-1:0][ADR_W-1:0] addr;
	} dbt_bp_cfg_s;

	localparam dbt_bp_cfg_s BP_CFG_RESET = '0;

endpackage

// *** logic/dbt_buf2.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes a single clock; source and sink share it.
module dbt_buf2 #(
	parameter int W = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);

	logic [DEPTH-1:0][W-1:0] mem_ff;
	logic [$clog2(DEPTH)-1:0] wr_ptr_ff;
	logic [$clog2(DEPTH)-1:0] rd_ptr_ff;
	logic [$clog2(DEPTH):0] count_ff;
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;

	assign in_ready_o = (count_ff != ($clog2(DEPTH)+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff <= count_ff + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push) mem_ff[wr_ptr_ff] <= in_data_i;
	end

endmodule // dbt_buf2

// *** logic/dbt_tap_top.sv ***
// Test access port controller with private debug chains and break unit.
// Assumes test pins are asynchronous to clk_sys_i and much slower than it.
module dbt_tap_top
	import dbt_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic port_enable_fuse_i,
	input wire logic port_disable_bit_i,
	input wire logic debug_enable_fuse_i,
	input wire logic lock_bit_set_i,
	input wire dbt_pins_s pins_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic pins_as_io_o,
	output logic pullup_en_o,
	output logic debug_active_o,
	output logic [IR_W-1:0] ir_o,
	output logic [3:0] tap_state_o,
	output logic [ADR_W-1:0] cpu_instr_o,
	output logic cpu_instr_valid_o,
	input wire logic cpu_instr_ready_i,
	input wire logic [ADR_W-1:0] cpu_result_i,
	input wire logic comm_wr_i,
	input wire logic [7:0] comm_data_i,
	output logic comm_dirty_o,
	output logic [7:0] comm_byte_o,
	input wire logic [ADR_W-1:0] pc_i,
	input wire logic pc_valid_i,
	input wire logic [ADR_W-1:0] data_addr_i,
	input wire logic data_valid_i,
	input wire logic flow_change_i,
	input wire logic step_done_i,
	output logic break_o,
	output logic [3:0] break_cause_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic dbt_state_e tap_next(input dbt_state_e st, input logic tms);
		dbt_state_e n;
		n = st;
		unique case (st)
			ST_RESET: n = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: n = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: n = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: n = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: n = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: n = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: n = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: n = tms ? ST_SEL_DR : ST_IDLE;
		endcase
		return n;
	endfunction

	// Shift right, new bit enters at the chain's top position
	function automatic logic [DR_MAX-1:0] dr_shift(input logic [DR_MAX-1:0] sr,
			input logic [6:0] len, input logic bit_in);
		logic [DR_MAX-1:0] r;
		r = sr >> 1;
		for (int i = 0; i < DR_MAX; i++) begin
			if (i == int'(len) - 1) r[i] = bit_in;
		end
		return r;
	endfunction

	function automatic logic is_debug_op(input logic [IR_W-1:0] op);
		return op[3:2] == OP_DEBUG_INSTR_A[3:2];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Enables and pin synchroniser

	wire port_on = port_enable_fuse_i & ~port_disable_bit_i;
	wire debug_on = port_on & debug_enable_fuse_i & ~lock_bit_set_i;

	assign pins_as_io_o = ~port_enable_fuse_i; // RQ14
	assign pullup_en_o = port_on; // RQ15
	assign debug_active_o = debug_on; // RQ21

	dbt_pins_s sync1_ff;
	dbt_pins_s sync2_ff;
	logic tck_d_ff;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			tck_d_ff <= 1'b0;
		end else begin
			sync1_ff <= pins_i;
			sync2_ff <= sync1_ff;
			tck_d_ff <= sync2_ff.tck;
		end
	end

	wire tck_rise = sync2_ff.tck & ~tck_d_ff;
	wire tck_fall = ~sync2_ff.tck & tck_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Controller state

	dbt_state_e state_ff;
	wire dbt_state_e nxt_state = tap_next(state_ff, sync2_ff.tms);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !port_on) begin
			state_ff <= ST_RESET; // RQ2 RQ14
		end else if (tck_rise) begin
			state_ff <= nxt_state; // RQ1 RQ13
		end
	end

	assign tap_state_o = state_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Instruction register

	logic [IR_W-1:0] ir_sr_ff;
	logic [IR_W-1:0] ir_ff;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || state_ff == ST_RESET) begin
			ir_sr_ff <= IR_CAPTURE;
			ir_ff <= IR_RESET_VAL;
		end else if (tck_rise) begin
			if (state_ff == ST_CAP_IR) begin
				ir_sr_ff <= IR_CAPTURE; // RQ6
			end else if (state_ff == ST_SHIFT_IR) begin
				ir_sr_ff <= {sync2_ff.tdi, ir_sr_ff[IR_W-1:1]}; // RQ3 RQ5
			end else if (state_ff == ST_UPD_IR) begin
				ir_ff <= ir_sr_ff; // RQ7
			end
		end
	end

	assign ir_o = ir_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Data register path selection

	wire sel_cpu = debug_on & (ir_ff == OP_DEBUG_INSTR_A); // RQ22 RQ18
	wire sel_bp = debug_on & (ir_ff == OP_DEBUG_INSTR_B); // RQ22
	wire sel_comm = debug_on & (ir_ff == OP_DEBUG_INSTR_C); // RQ22
	wire sel_stat = debug_on & (ir_ff == OP_DEBUG_INSTR_D); // RQ22
	wire debug_sel = debug_on & is_debug_op(ir_ff);

	wire [6:0] dr_len = sel_cpu ? LEN_CPU :
		sel_bp ? LEN_BP :
		sel_comm ? LEN_COMM :
		sel_stat ? LEN_STAT : LEN_BYPASS;

	dbt_bp_cfg_s bp_cfg_ff;
	logic [7:0] comm_ff;
	logic comm_dirty_ff;
	logic [3:0] cause_ff;

	wire [DR_MAX-1:0] cap_cpu = {{(DR_MAX-ADR_W){1'b0}}, cpu_result_i};
	wire [DR_MAX-1:0] cap_comm = {{(DR_MAX-9){1'b0}}, comm_dirty_ff, comm_ff};
	wire [DR_MAX-1:0] cap_stat = {{(DR_MAX-4){1'b0}}, cause_ff};
	wire [DR_MAX-1:0] dr_capture = sel_cpu ? cap_cpu :
		sel_bp ? DR_MAX'(bp_cfg_ff) :
		sel_comm ? cap_comm :
		sel_stat ? cap_stat : '0;

	logic [DR_MAX-1:0] dr_sr_ff;

	// Exit, pause and exit2 states fall through untouched
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			dr_sr_ff <= '0;
		end else if (tck_rise) begin
			if (state_ff == ST_CAP_DR) begin
				dr_sr_ff <= dr_capture; // RQ9
			end else if (state_ff == ST_SHIFT_DR) begin
				dr_sr_ff <= dr_shift(dr_sr_ff, dr_len, sync2_ff.tdi); // RQ3 RQ8 RQ11
			end
		end
	end

	// Update pulse; reachable straight after Update-IR via Select-DR
	wire upd_dr = tck_rise & (state_ff == ST_UPD_DR); // RQ10 RQ12

	////////////////////////////////////////////////////////////////////////////////
	// Test data out, changed on falling test clock

	logic tdo_ff;
	logic tdo_oe_ff;
	wire shifting = (state_ff == ST_SHIFT_IR) | (state_ff == ST_SHIFT_DR);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !port_on) begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else if (tck_fall) begin
			tdo_ff <= (state_ff == ST_SHIFT_IR) ? ir_sr_ff[0] : dr_sr_ff[0]; // RQ23 RQ3
			tdo_oe_ff <= shifting; // RQ16
		end
	end

	assign tdo_o = tdo_ff;
	assign tdo_oe_o = tdo_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Processor instruction feed through two-entry buffer

	logic [ADR_W-1:0] instr_hold_ff;
	logic push_pend_ff;
	logic buf_in_ready;

	// A new word while one still waits is dropped
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !debug_on) begin
			instr_hold_ff <= '0;
			push_pend_ff <= 1'b0;
		end else if (upd_dr && sel_cpu && !push_pend_ff) begin
			instr_hold_ff <= dr_sr_ff[ADR_W-1:0]; // RQ18 RQ10
			push_pend_ff <= 1'b1;
		end else if (push_pend_ff && buf_in_ready) begin
			push_pend_ff <= 1'b0;
		end
	end

	dbt_buf2 #(
		.W(ADR_W),
		.DEPTH(2)
	) u_instr_buf (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.in_data_i(instr_hold_ff),
		.in_valid_i(push_pend_ff),
		.in_ready_o(buf_in_ready),
		.out_data_o(cpu_instr_o),
		.out_valid_o(cpu_instr_valid_o),
		.out_ready_i(cpu_instr_ready_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Communication byte from processor

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			comm_ff <= COMM_RESET;
			comm_dirty_ff <= 1'b0;
		end else if (comm_wr_i) begin
			comm_ff <= comm_data_i; // RQ18
			comm_dirty_ff <= 1'b1;
		end else if (upd_dr && sel_comm) begin
			comm_dirty_ff <= 1'b0;
		end
	end

	assign comm_dirty_o = comm_dirty_ff;
	assign comm_byte_o = comm_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Break point configuration

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i) begin
			bp_cfg_ff <= BP_CFG_RESET;
		end else if (upd_dr && sel_bp) begin
			bp_cfg_ff <= dbt_bp_cfg_s'(dr_sr_ff); // RQ10 RQ20
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Break point matching

	wire [2:0] mode = bp_cfg_ff.mode;
	wire range_mode = (mode == BPM_2PROG_PRANGE) | (mode == BPM_2PROG_DRANGE);
	logic [BP_N-1:0] bp_prog;
	logic [BP_N-1:0] bp_data;

	// Two fixed program points, two combined points
	genvar k;
	generate
		for (k = 0; k < BP_N; k++) begin : g_bp
			wire is_data = (k == 3) ? (mode == BPM_3PROG_1DATA) | (mode == BPM_2PROG_2DATA) :
				(k == 2) ? (mode == BPM_2PROG_2DATA) : 1'b0;
			wire single = (k < 2) | ~range_mode;
			assign bp_prog[k] = single & ~is_data & pc_valid_i
				& (pc_i == bp_cfg_ff.addr[k]); // RQ19 RQ20
			assign bp_data[k] = single & is_data & data_valid_i
				& (data_addr_i == bp_cfg_ff.addr[k]); // RQ19 RQ20
		end
	endgenerate

	// Point 2 is the base, point 3 the mask
	wire [ADR_W-1:0] rmask = bp_cfg_ff.addr[3];
	wire [ADR_W-1:0] rbase = bp_cfg_ff.addr[2] & rmask;
	wire prange_hit = (mode == BPM_2PROG_PRANGE) & pc_valid_i
		& ((pc_i & rmask) == rbase); // RQ20
	wire drange_hit = (mode == BPM_2PROG_DRANGE) & data_valid_i
		& ((data_addr_i & rmask) == rbase); // RQ20

	wire [3:0] nxt_cause;
	assign nxt_cause[CAUSE_PROG] = (|bp_prog) | prange_hit;
	assign nxt_cause[CAUSE_DATA] = (|bp_data) | drange_hit;
	assign nxt_cause[CAUSE_FLOW] = bp_cfg_ff.flow_en & flow_change_i; // RQ19
	assign nxt_cause[CAUSE_STEP] = bp_cfg_ff.step_en & step_done_i; // RQ19

	logic break_ff;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || !debug_on) begin
			break_ff <= 1'b0;
			cause_ff <= CAUSE_RESET;
		end else begin
			break_ff <= |nxt_cause; // RQ21
			if (|nxt_cause) cause_ff <= nxt_cause;
		end
	end

	assign break_o = break_ff;
	assign break_cause_o = cause_ff;

	// Never used; each chain select decodes ir_ff on its own
	wire unused_sel = debug_sel;

endmodule // dbt_tap_top

// *** tb/dbt_jtag_model.sv ***
// Probe model: drives test clock, mode select and data in.
// Assumes data out sits on a board pull-up and the clock is 40 MHz.
module dbt_jtag_model
	import dbt_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_b_i,
	input wire logic tdo_i,
	input wire logic tdo_oe_i,
	output dbt_pins_s pins_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tdo_line;
	assign tdo_line = tdo_oe_i ? tdo_i : 1'b1;
	initial pins_o = '0;
	// One 200 ns test clock period, entered just after a clock edge
	task automatic tick(input logic tms, input logic tdi, output logic tdo);
		// System reset seen: steer towards test logic reset
		pins_o = {1'b0, tms | ~sys_rst_b_i, tdi};
		repeat (4) @(posedge clk_sys_i);
		#1 tdo = tdo_line;
		pins_o.tck = 1'b1;
		repeat (4) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic shift(input logic [68:0] din, input int n, output logic [68:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], dout[i]);
		end
	endtask
endmodule // dbt_jtag_model

// *** tb/dbt_tap_sva.sv ***
// Checker for the debug test port, watching the top module's ports.
// Assumes one clock domain with synchronous active-low reset.
module dbt_tap_sva
	import dbt_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic port_enable_fuse_i,
	input wire logic port_disable_bit_i,
	input wire logic debug_enable_fuse_i,
	input wire logic lock_bit_set_i,
	input wire dbt_pins_s pins_i,
	input wire logic tdo_oe_o,
	input wire logic pins_as_io_o,
	input wire logic pullup_en_o,
	input wire logic debug_active_o,
	input wire logic [IR_W-1:0] ir_o,
	input wire logic [3:0] tap_state_o,
	input wire logic comm_wr_i,
	input wire logic [7:0] comm_data_i,
	input wire logic comm_dirty_o,
	input wire logic [7:0] comm_byte_o,
	input wire logic break_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	logic tck_q;
	logic [2:0] ones_ff;
	always_ff @(posedge clk_sys_i) tck_q <= pins_i.tck;
	// Counts test clock rises with mode select high
	always_ff @(posedge clk_sys_i) begin
		if (!rst_b_i || (pins_i.tck && !tck_q && !pins_i.tms)) ones_ff <= 3'h0;
		else if (pins_i.tck && !tck_q && ones_ff != 3'h5) ones_ff <= ones_ff + 3'h1;
	end
	property p_io; pins_as_io_o == !port_enable_fuse_i; endproperty
	a_io: assert property (p_io) else $error("pin mode wrong");
	property p_pu; pullup_en_o == (port_enable_fuse_i && !port_disable_bit_i); endproperty
	a_pu: assert property (p_pu) else $error("port enable wrong");
	property p_act;
		debug_active_o == (pullup_en_o && debug_enable_fuse_i && !lock_bit_set_i);
	endproperty
	a_act: assert property (p_act) else $error("debug enable wrong");
	property p_off; !pullup_en_o ##1 !pullup_en_o |-> tap_state_o == ST_RESET && !tdo_oe_o; endproperty
	a_off: assert property (p_off) else $error("controller not held");
	property p_oe;
		tdo_oe_o |-> tap_state_o inside {ST_SHIFT_IR, ST_SHIFT_DR, ST_EXIT1_IR, ST_EXIT1_DR};
	endproperty
	a_oe: assert property (p_oe) else $error("data out driven outside shift");
	property p_ir;
		!$stable(ir_o) |-> $past(tap_state_o) inside {ST_UPD_IR, ST_RESET} || tap_state_o == ST_RESET;
	endproperty
	a_ir: assert property (p_ir) else $error("instruction changed outside update");
	property p_tck; (!pins_i.tck && pullup_en_o) [*4] |-> $stable(tap_state_o); endproperty
	a_tck: assert property (p_tck) else $error("state moved without clock rise");
	property p_tlr; $rose(ones_ff == 3'h5) |-> ##[1:6] tap_state_o == ST_RESET; endproperty
	a_tlr: assert property (p_tlr) else $error("five ones did not reset");
	property p_comm; comm_wr_i |=> comm_dirty_o && comm_byte_o == $past(comm_data_i); endproperty
	a_comm: assert property (p_comm) else $error("comm byte not taken");
	property p_brk; !debug_active_o ##1 !debug_active_o |-> !break_o; endproperty
	a_brk: assert property (p_brk) else $error("break while debug off");
	c_shift: cover property (tap_state_o == ST_SHIFT_DR);
	c_brk: cover property (break_o);
	c_tlr: cover property ($rose(ones_ff == 3'h5));
endmodule // dbt_tap_sva

// *** tb/dbt_tap_top_bench.sv ***
// Bench for the debug test port: a probe model walks the controller.
// Assumes a 40 MHz clock and a 200 ns test clock.
module dbt_tap_top_bench
	import dbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rst_b_i, port_enable_fuse_i, port_disable_bit_i, debug_enable_fuse_i, lock_bit_set_i;
	logic cpu_instr_ready_i, comm_wr_i, pc_valid_i, data_valid_i, flow_change_i, step_done_i;
	logic [15:0] cpu_result_i, pc_i, data_addr_i, cpu_instr_o;
	logic [7:0] comm_data_i, comm_byte_o;
	dbt_pins_s pins_i;
	logic tdo_o, tdo_oe_o, pins_as_io_o, pullup_en_o, debug_active_o, cpu_instr_valid_o;
	logic comm_dirty_o, break_o;
	logic [3:0] ir_o, tap_state_o, break_cause_o;
	logic [68:0] d;
	int fail_count = 0;
	int n_checks = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	dbt_tap_top i_dut (.*);
	dbt_jtag_model u_prb (.clk_sys_i(clk_sys_i), .sys_rst_b_i(rst_b_i), .tdo_i(tdo_o),
		.tdo_oe_i(tdo_oe_o), .pins_o(pins_i));
	////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [68:0] seen, input logic [68:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic walk(input logic [3:0] t, input int n);
		logic x;
		for (int i = 0; i < n; i++) begin
			u_prb.tick(t[i], 1'b0, x);
		end
	endtask
	task automatic ir_load(input logic [3:0] op, input logic to_dr);
		walk(4'h3, 4);
		u_prb.shift({65'h0, op}, 4, d);
		chk("ir_capture", d[3:0], IR_CAPTURE);
		walk(to_dr ? 4'h3 : 4'h1, to_dr ? 4 : 2);
		chk("ir", ir_o, op);
	endtask
	task automatic dr(input logic [68:0] din, input int n, input int pre);
		walk(4'h1, pre);
		u_prb.shift(din, n, d);
	endtask
	task automatic hit(input logic [3:0] ev, input logic exp, input logic [3:0] cause);
		{step_done_i, pc_valid_i, data_valid_i, flow_change_i} = ev;
		cyc(1);
		{step_done_i, pc_valid_i, data_valid_i, flow_change_i} = 4'h0;
		for (int i = 0; i < 3 && break_o !== 1'b1; i++) begin
			cyc(1);
		end
		chk("break", break_o, exp);
		if (exp) begin
			chk("cause", break_cause_o, cause);
		end
		cyc(2);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b_i, port_enable_fuse_i, port_disable_bit_i, lock_bit_set_i} = 4'h0;
		{debug_enable_fuse_i, cpu_instr_ready_i, comm_wr_i, pc_valid_i} = 4'h8;
		{data_valid_i, flow_change_i, step_done_i} = 3'h0;
		{cpu_result_i, pc_i, data_addr_i, comm_data_i} = {16'ha5c3, 16'h0040, 16'h0200, 8'h5a};
		cyc(20);
		rst_b_i = 1'b1;
		cyc(1);
		chk("state", tap_state_o, ST_RESET);
		chk("ir_reset", ir_o, IR_RESET_VAL);
		chk("io", pins_as_io_o, 1'b1);
		walk(4'h3, 4);
		chk("held", tap_state_o, ST_RESET);
		port_enable_fuse_i = 1'b1;
		cyc(1);
		chk("pullup", pullup_en_o, 1'b1);
		chk("active", debug_active_o, 1'b1);
		walk(4'h0, 1);
		chk("idle", tap_state_o, ST_IDLE);
		// Stalled processor: two words buffered, one pending, one dropped
		ir_load(OP_DEBUG_INSTR_A, 1'b0);
		for (int k = 0; k < 4; k++) begin
			dr(69'hc0d0 + k, 16, 3);
			chk("result", d[15:0], 16'ha5c3);
			chk("pre_update", cpu_instr_valid_o, k > 0);
			walk(4'h1, 2);
		end
		cyc(3);
		for (int k = 0; k < 3; k++) begin
			chk("word", {cpu_instr_valid_o, cpu_instr_o}, {1'b1, 16'hc0d0 + k[15:0]});
			cpu_instr_ready_i = 1'b1;
			cyc(1);
			cpu_instr_ready_i = 1'b0;
			cyc(3);
		end
		chk("empty", cpu_instr_valid_o, 1'b0);
		comm_wr_i = 1'b1;
		cyc(1);
		comm_wr_i = 1'b0;
		ir_load(OP_DEBUG_INSTR_C, 1'b1);
		dr('0, 9, 0);
		chk("comm", d[8:0], {1'b1, 8'h5a});
		walk(4'h1, 2);
		chk("dirty", comm_dirty_o, 1'b0);
		ir_load(OP_DEBUG_INSTR_B, 1'b0);
		dr({BPM_4PROG, 2'h2, 48'h0, 16'h0040}, 69, 3);
		walk(4'h1, 2);
		hit(3'h4, 1'b1, 4'h1);
		hit(3'h1, 1'b1, 4'h4);
		// Program range with single step, then data range
		dr({BPM_2PROG_PRANGE, 2'h1, 16'hff00, 16'h0000, 32'hffff_ffff}, 69, 3);
		walk(4'h1, 2);
		hit(4'h4, 1'b1, 4'h1);
		hit(4'h8, 1'b1, 4'h8);
		dr({BPM_2PROG_DRANGE, 2'h0, 16'hff00, 16'h0200, 32'hffff_ffff}, 69, 3);
		walk(4'h1, 2);
		hit(4'h2, 1'b1, 4'h2);
		hit(4'h4, 1'b0, 4'h0);
		dr({BPM_2PROG_2DATA, 2'h0, 16'h0, 16'h0200, 32'h0}, 69, 3);
		walk(4'h1, 2);
		hit(3'h2, 1'b1, 4'h2);
		hit(3'h4, 1'b0, 4'h0);
		ir_load(OP_DEBUG_INSTR_D, 1'b0);
		dr('0, 8, 3);
		chk("cause_chain", d[7:0], 8'h02);
		walk(4'h1, 2);
		lock_bit_set_i = 1'b1;
		cyc(1);
		chk("locked", debug_active_o, 1'b0);
		hit(3'h2, 1'b0, 4'h0);
		walk(4'h1, 4);
		chk("drive", tdo_oe_o, 1'b1);
		walk(4'hf, 4);
		walk(4'h1, 1);
		chk("tlr", tap_state_o, ST_RESET);
		cyc(8);
		chk("float", tdo_oe_o, 1'b0);
		port_disable_bit_i = 1'b1;
		cyc(1);
		chk("disabled", {pullup_en_o, pins_as_io_o}, 2'h0);
		test_done;
	end
	initial begin
		cyc(12000);
		fail_count++;
		test_done;
	end
endmodule // dbt_tap_top_bench

bind dbt_tap_top dbt_tap_sva i_sva (.*);
